// File: rtl/spisc_top.sv
// SPI select and control: control register, select-pin handling, slave receive shifter.
// Assumes an APB master on clk and SPI pins asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module spisc_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe,
    output logic misoOut,
    output logic misoOe,
    input wire logic selectIn,
    output logic selectOut,
    output logic selectOe
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [1:0] status_r;
    logic [1:0] mask_r;
    logic [4:0] dir_r;
    logic [7:0] shift_r;
    logic [7:0] rxData_r;
    logic [2:0] bitCnt_r;
    logic sckPrev_r;
    logic selPrev_r;
    logic [2:0] pinSync;
    logic sckS;
    logic mosiS;
    logic selS;
    logic portEn;
    logic isMaster;
    logic slaveActive;
    logic contention;
    logic sampleEdge;
    logic byteDone;
    logic apbAccess;
    logic apbWrite;
    logic apbRead;
    logic mapped;
    logic [1:0] status_nxt;

    function automatic logic hitAddr(input logic [7:0] a, input logic [7:0] off);
        hitAddr = (a == off);
    endfunction : hitAddr

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Select travels inverted through the synchroniser, so that its reset value of zero
    // reads as an idle high select and no false select edge follows reset.
    spisc_sync #(.WIDTH(3)) pinSyncInst (
        .clk(clk),
        .reset_n(reset_n),
        .asyncIn({~selectIn, mosiIn, sckIn}),
        .syncOut(pinSync)
    );
    assign sckS = pinSync[0];
    assign mosiS = pinSync[1];
    assign selS = ~pinSync[2];

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign portEn = ctrl_r[spisc_pkg::CTRL_PORT_EN_POS];
    assign isMaster = portEn && ctrl_r[spisc_pkg::CTRL_MASTER_POS];
    // Select is an input in master mode unless software made it an output.
    assign contention = isMaster && !dir_r[spisc_pkg::DIR_SS_POS] && !selS;
    assign slaveActive = portEn && !ctrl_r[spisc_pkg::CTRL_MASTER_POS] && !selS;
    // Sample edge: leading when phase is 0, trailing otherwise.
    assign sampleEdge = (sckS != sckPrev_r)
        && ((sckS ^ ctrl_r[spisc_pkg::CTRL_CLOCK_POLARITY_POS]) ^ ctrl_r[spisc_pkg::CTRL_CLOCK_PHASE_POS]);
    assign byteDone = slaveActive && sampleEdge && (bitCnt_r == 3'h7);

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign apbAccess = psel && penable;
    assign apbWrite = apbAccess && pwrite;
    // A read is taken in its setup cycle, where the read data is latched, so that a status
    // bit set after that edge is not lost to the clear.
    assign apbRead = psel && !penable && !pwrite;
    assign mapped = hitAddr(paddr, spisc_pkg::CTRL_OFFSET)
        || hitAddr(paddr, spisc_pkg::STATUS_OFFSET)
        || hitAddr(paddr, spisc_pkg::MASK_OFFSET)
        || hitAddr(paddr, spisc_pkg::DIR_OFFSET)
        || hitAddr(paddr, spisc_pkg::PINS_OFFSET);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= spisc_pkg::CTRL_RESET;
        end else if (apbWrite && hitAddr(paddr, spisc_pkg::CTRL_OFFSET)) begin
            ctrl_r <= pwdata[7:0];
        end else if (contention) begin
            ctrl_r[spisc_pkg::CTRL_MASTER_POS] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Direction and mask registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dir_r <= spisc_pkg::DIR_RESET;
        end else if (apbWrite && hitAddr(paddr, spisc_pkg::DIR_OFFSET)) begin
            dir_r <= pwdata[4:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_r <= spisc_pkg::MASK_RESET;
        end else if (apbWrite && hitAddr(paddr, spisc_pkg::MASK_OFFSET)) begin
            mask_r <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Status: sticky, cleared by a read, a new event wins over the clear
    // ------------------------------------------------------------
    always_comb begin
        status_nxt = status_r;
        if (apbRead && hitAddr(paddr, spisc_pkg::STATUS_OFFSET)) begin
            status_nxt = spisc_pkg::STAT_RESET;
        end
        if (contention) begin
            status_nxt[spisc_pkg::STAT_DONE_POS] = 1'b1;
            status_nxt[spisc_pkg::STAT_CONTEND_POS] = 1'b1;
        end
        if (byteDone) begin
            status_nxt[spisc_pkg::STAT_DONE_POS] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_r <= spisc_pkg::STAT_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Transfer-done reaches the line only with the irq enable bit set.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (status_nxt[spisc_pkg::STAT_DONE_POS] && mask_r[spisc_pkg::STAT_DONE_POS]
                    && ctrl_r[spisc_pkg::CTRL_IRQ_EN_POS])
                || (status_nxt[spisc_pkg::STAT_CONTEND_POS]
                    && mask_r[spisc_pkg::STAT_CONTEND_POS]);
        end
    end

    // ------------------------------------------------------------
    // Slave receive shifter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sckPrev_r <= 1'b0;
            selPrev_r <= 1'b1;
        end else begin
            sckPrev_r <= sckS;
            selPrev_r <= selS;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_r <= spisc_pkg::SHIFT_RESET;
            bitCnt_r <= spisc_pkg::BITCNT_RESET;
            rxData_r <= spisc_pkg::SHIFT_RESET;
        end else if (!slaveActive) begin
            shift_r <= spisc_pkg::SHIFT_RESET;
            bitCnt_r <= spisc_pkg::BITCNT_RESET;
        end else if (sampleEdge) begin
            bitCnt_r <= bitCnt_r + 3'h1;
            if (ctrl_r[spisc_pkg::CTRL_ORDER_POS]) begin
                shift_r <= {mosiS, shift_r[7:1]};
            end else begin
                shift_r <= {shift_r[6:0], mosiS};
            end
            if (bitCnt_r == 3'h7) begin
                rxData_r <= ctrl_r[spisc_pkg::CTRL_ORDER_POS]
                    ? {mosiS, shift_r[7:1]} : {shift_r[6:0], mosiS};
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sckOe <= 1'b0;
            mosiOe <= 1'b0;
            misoOe <= 1'b0;
            selectOe <= 1'b0;
        end else begin
            sckOe <= isMaster && !contention && dir_r[spisc_pkg::DIR_SCK_POS];
            mosiOe <= isMaster && !contention && dir_r[spisc_pkg::DIR_MOSI_POS];
            misoOe <= (!isMaster || contention) && dir_r[spisc_pkg::DIR_MISO_POS];
            selectOe <= isMaster && !contention && dir_r[spisc_pkg::DIR_SS_POS];
        end
    end

    // SCK only idles at its polarity level: this block makes no master clock of its own.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sckOut <= 1'b0;
            mosiOut <= 1'b0;
            misoOut <= 1'b0;
            selectOut <= 1'b0;
        end else begin
            sckOut <= ctrl_r[spisc_pkg::CTRL_CLOCK_POLARITY_POS];
            mosiOut <= 1'b0;
            misoOut <= slaveActive ? shift_r[7] : 1'b0;
            selectOut <= dir_r[spisc_pkg::DIR_SSOUT_POS];
        end
    end

    // ------------------------------------------------------------
    // APB read data and answer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= spisc_pkg::RDATA_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= spisc_pkg::RDATA_RESET;
            if (apbRead) begin
                unique case (1'b1)
                    hitAddr(paddr, spisc_pkg::CTRL_OFFSET): prdata[7:0] <= ctrl_r;
                    hitAddr(paddr, spisc_pkg::STATUS_OFFSET): prdata[1:0] <= status_r;
                    hitAddr(paddr, spisc_pkg::MASK_OFFSET): prdata[1:0] <= mask_r;
                    hitAddr(paddr, spisc_pkg::DIR_OFFSET): prdata[4:0] <= dir_r;
                    hitAddr(paddr, spisc_pkg::PINS_OFFSET): prdata[18:0] <=
                        {selS, mosiS, sckS, bitCnt_r, 5'h00, rxData_r};
                    default: prdata <= spisc_pkg::RDATA_RESET;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    master_drop_a: assert property (contention && !(apbWrite
        && hitAddr(paddr, spisc_pkg::CTRL_OFFSET)) |=> !ctrl_r[spisc_pkg::CTRL_MASTER_POS])
        else $error("master select not cleared on contention");
    done_set_a: assert property (contention |=> status_r[spisc_pkg::STAT_DONE_POS])
        else $error("done flag not set on contention");
    stay_slave_a: assert property (!ctrl_r[spisc_pkg::CTRL_MASTER_POS] && !apbWrite
        |=> !ctrl_r[spisc_pkg::CTRL_MASTER_POS])
        else $error("master mode returned without a write");
    slave_sel_in_a: assert property (!isMaster |=> !selectOe)
        else $error("select driven in slave mode");
    passive_a: assert property (!slaveActive |=> bitCnt_r == 3'h0)
        else $error("shifting while passive");
    reset_on_high_a: assert property (selS && !selPrev_r |=> shift_r == 8'h00)
        else $error("shift logic kept after select rose");
    miso_user_a: assert property (!isMaster ##1 !isMaster |-> misoOe
        == $past(dir_r[spisc_pkg::DIR_MISO_POS]))
        else $error("miso direction not under software");
    lines_in_a: assert property (contention |=> !sckOe && !mosiOe)
        else $error("sck or mosi driven during contention");
    port_off_a: assert property (!portEn |=> !sckOe && !mosiOe && !selectOe)
        else $error("pins driven while port disabled");
    port_idle_a: assert property (!portEn |=> !$rose(status_r[spisc_pkg::STAT_DONE_POS]))
        else $error("done flag set while port disabled");
    slave_lines_in_a: assert property (!isMaster |=> !sckOe && !mosiOe)
        else $error("sck or mosi driven in slave mode");
    passive_miso_a: assert property (selS |=> misoOut == 1'b0)
        else $error("miso data while select high");
    byte_flag_a: assert property (byteDone |=> status_r[spisc_pkg::STAT_DONE_POS])
        else $error("done flag not set after a byte");
    contend_irq_a: assert property (contention && mask_r[spisc_pkg::STAT_CONTEND_POS]
        |=> irq)
        else $error("contention raised no interrupt");
    select_out_a: assert property (isMaster && dir_r[spisc_pkg::DIR_SS_POS] |=> selectOe)
        else $error("output select not driven in master mode");
    gp_select_a: assert property (isMaster && dir_r[spisc_pkg::DIR_SS_POS] |=> !contention
        && selectOut == $past(dir_r[spisc_pkg::DIR_SSOUT_POS]))
        else $error("output select affected the port");


    // ------------------------------------------------------------
    // Assertions on the register bus
    // ------------------------------------------------------------
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held for more than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error answer without ready");
    rdata_idle_a: assert property (!pready |-> prdata == spisc_pkg::RDATA_RESET)
        else $error("read data outside the answer cycle");
    ctrl_write_a: assert property (apbWrite && hitAddr(paddr, spisc_pkg::CTRL_OFFSET)
        |=> ctrl_r == $past(pwdata[7:0]))
        else $error("control write did not land");
    dir_write_a: assert property (apbWrite && hitAddr(paddr, spisc_pkg::DIR_OFFSET)
        |=> dir_r == $past(pwdata[4:0]))
        else $error("direction write did not land");
    mask_write_a: assert property (apbWrite && hitAddr(paddr, spisc_pkg::MASK_OFFSET)
        |=> mask_r == $past(pwdata[1:0]))
        else $error("mask write did not land");

    contend_c: cover property (contention ##1 irq);
    byte_c: cover property (byteDone);
    rewrite_c: cover property (contention ##[1:20] isMaster);
    cut_byte_c: cover property (slaveActive && bitCnt_r != 3'h0 ##1 !slaveActive);
    gp_select_c: cover property (isMaster && selectOe);
endmodule : spisc_top
`default_nettype wire

// File: rtl/spisc_pkg.sv
// Package of the SPI select and control block: register map, field positions, reset values.
// Assumes a 32-bit APB slave with one aligned word per register.
package spisc_pkg;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET = 8'h08;
    localparam logic [7:0] DIR_OFFSET = 8'h0C;
    localparam logic [7:0] PINS_OFFSET = 8'h10;
    localparam int CTRL_IRQ_EN_POS = 7;
    localparam int CTRL_PORT_EN_POS = 6;
    localparam int CTRL_ORDER_POS = 5;
    localparam int CTRL_MASTER_POS = 4;
    localparam int CTRL_CLOCK_POLARITY_POS = 3;
    localparam int CTRL_CLOCK_PHASE_POS = 2;
    localparam int CTRL_RATE_HI_POS = 1;
    localparam int CTRL_RATE_LO_POS = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int STAT_DONE_POS = 0;
    localparam int STAT_CONTEND_POS = 1;
    localparam logic [1:0] STAT_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam int DIR_MOSI_POS = 0;
    localparam int DIR_MISO_POS = 1;
    localparam int DIR_SCK_POS = 2;
    localparam int DIR_SS_POS = 3;
    localparam int DIR_SSOUT_POS = 4;
    localparam logic [4:0] DIR_RESET = 5'h00;
    localparam logic [2:0] BITCNT_RESET = 3'h0;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h00000000;
endpackage : spisc_pkg

// File: rtl/spisc_sync.sv
// Two flip-flop synchroniser for a group of pins.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module spisc_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_r <= '0;
            syncOut <= '0;
        end else begin
            stage1_r <= asyncIn;
            syncOut <= stage1_r;
        end
    end
endmodule : spisc_sync
`default_nettype wire

// File: verification/spisc_far_master.sv
// Behavioural outside SPI master driving select, SCK and MOSI of the port.
// Assumes SCK mode 0, MSB first, a 160 ns SCK period and a pull-up on select.
`timescale 1ns/100ps
`default_nettype none
module spisc_far_master (
    output logic sck,
    output logic mosi,
    output logic sel
);
    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    initial begin
        sck = 1'h0;
        mosi = 1'h0;
        sel = 1'h1;
    end

    task automatic selSet(input logic level);
        #80;
        sel = level;
        #80;
    endtask : selSet

    // Between bits SCK stands still; after a frame MOSI shows the inverse of its last bit.
    task automatic sendBits(input logic [7:0] data, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            mosi = data[i];
            #80;
            sck = 1'h1;
            #80;
            sck = 1'h0;
        end
        mosi = ~mosi;
    endtask : sendBits
endmodule : spisc_far_master
`default_nettype wire

// File: verification/spi_select_and_control_bench.sv
// Self-checking bench for the SPI select and control block.
// Assumes the outside master model on the pins and APB access to the registers.
`timescale 1ns/100ps
`default_nettype none
module spi_select_and_control_bench;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready, pslverr, irq, err;
    logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, selectOut, selectOe;
    logic farSck, farMosi, farSel;
    logic [31:0] rd;
    int fails = 0;
    int checked = 0;

    always #5 clk = ~clk;

    spisc_top u_spisc_top (
        .clk(clk),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq),
        .sckIn(sckOe ? sckOut : farSck),
        .sckOut(sckOut),
        .sckOe(sckOe),
        .mosiIn(mosiOe ? mosiOut : farMosi),
        .mosiOut(mosiOut),
        .mosiOe(mosiOe),
        .misoOut(misoOut),
        .misoOe(misoOe),
        .selectIn(selectOe ? selectOut : farSel),
        .selectOut(selectOut),
        .selectOe(selectOe)
    );

    spisc_far_master u_spisc_far_master (
        .sck(farSck),
        .mosi(farMosi),
        .sel(farSel)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic close_out();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; read data and error are taken at the edge that sees pready.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (pready !== 1'h1) begin
            fails++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'h0, a, 32'h00000000);
        chk(rd, exp);
    endtask : rdc

    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask : settle

    task automatic waitIrq(input logic level);
        int n;
        n = 0;
        while (irq !== level && n < 3000) begin
            @(posedge clk);
            n++;
        end
        #1;
        if (irq !== level) begin
            fails++;
            close_out();
        end
    endtask : waitIrq

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        psel <= 1'h0;
        penable <= 1'h0;
        pwrite <= 1'h0;
        paddr <= 8'h00;
        pwdata <= 32'h00000000;
        repeat (2) @(posedge clk);
        reset_n <= 1'h1;
        rdc(spisc_pkg::CTRL_OFFSET, 32'h00000000);
        rdc(spisc_pkg::STATUS_OFFSET, 32'h00000000);
        rdc(spisc_pkg::MASK_OFFSET, 32'h00000000);
        wr(spisc_pkg::CTRL_OFFSET, 32'h000000AF);
        rdc(spisc_pkg::CTRL_OFFSET, 32'h000000AF);
        rdc(8'h14, 32'h00000000);
        chk({31'h0, err}, 32'h00000001);
        wr(spisc_pkg::CTRL_OFFSET, 32'h00000000);
        wr(spisc_pkg::MASK_OFFSET, 32'h00000003);
        u_spisc_far_master.selSet(1'h0);
        u_spisc_far_master.sendBits(8'h5A, 8);
        u_spisc_far_master.selSet(1'h1);
        rdc(spisc_pkg::STATUS_OFFSET, 32'h00000000);
        wr(spisc_pkg::CTRL_OFFSET, 32'h000000C0);
        wr(spisc_pkg::DIR_OFFSET, 32'h0000001A);
        settle();
        chk({31'h0, selectOe}, 32'h00000000);
        chk({31'h0, misoOe}, 32'h00000001);
        u_spisc_far_master.selSet(1'h0);
        settle();
        chk({31'h0, misoOe}, 32'h00000001);
        chk({30'h0, sckOe, mosiOe}, 32'h00000000);
        u_spisc_far_master.sendBits(8'hA5, 8);
        waitIrq(1'h1);
        chk({31'h0, misoOut}, 32'h00000001);
        rdc(spisc_pkg::STATUS_OFFSET, 32'h00000001);
        xfer(1'h0, spisc_pkg::PINS_OFFSET, 32'h00000000);
        chk(rd & 32'h000000FF, 32'h000000A5);
        u_spisc_far_master.sendBits(8'hFF, 3);
        u_spisc_far_master.selSet(1'h1);
        xfer(1'h0, spisc_pkg::PINS_OFFSET, 32'h00000000);
        chk({29'h0, rd[15:13]}, 32'h00000000);
        wr(spisc_pkg::DIR_OFFSET, 32'h00000000);
        settle();
        chk({31'h0, misoOe}, 32'h00000000);
        u_spisc_far_master.sendBits(8'h81, 8);
        settle();
        chk({30'h0, sckOe, mosiOe}, 32'h00000000);
        rdc(spisc_pkg::STATUS_OFFSET, 32'h00000000);
        u_spisc_far_master.selSet(1'h0);
        u_spisc_far_master.sendBits(8'h3C, 8);
        waitIrq(1'h1);
        wr(spisc_pkg::MASK_OFFSET, 32'h00000002);
        settle();
        chk({31'h0, irq}, 32'h00000000);
        rdc(spisc_pkg::STATUS_OFFSET, 32'h00000001);
        xfer(1'h0, spisc_pkg::PINS_OFFSET, 32'h00000000);
        chk(rd & 32'h000000FF, 32'h0000003C);
        u_spisc_far_master.selSet(1'h1);
        wr(spisc_pkg::MASK_OFFSET, 32'h00000003);
        wr(spisc_pkg::DIR_OFFSET, 32'h00000005);
        wr(spisc_pkg::CTRL_OFFSET, 32'h000000D0);
        settle();
        chk({30'h0, sckOe, mosiOe}, 32'h00000003);
        u_spisc_far_master.selSet(1'h0);
        waitIrq(1'h1);
        chk({30'h0, sckOe, mosiOe}, 32'h00000000);
        rdc(spisc_pkg::CTRL_OFFSET, 32'h000000C0);
        rdc(spisc_pkg::STATUS_OFFSET, 32'h00000003);
        u_spisc_far_master.selSet(1'h1);
        settle();
        rdc(spisc_pkg::CTRL_OFFSET, 32'h000000C0);
        wr(spisc_pkg::CTRL_OFFSET, 32'h000000D0);
        rdc(spisc_pkg::CTRL_OFFSET, 32'h000000D0);
        wr(spisc_pkg::DIR_OFFSET, 32'h0000000D);
        settle();
        chk({30'h0, selectOe, selectOut}, 32'h00000002);
        rdc(spisc_pkg::CTRL_OFFSET, 32'h000000D0);
        rdc(spisc_pkg::STATUS_OFFSET, 32'h00000000);
        close_out();
    end
endmodule : spi_select_and_control_bench
`default_nettype wire
